// ===== rtl/pcg_top.sv
`include "pcg_consts.svh"
`default_nettype none
module pcg_top
  import pcg_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // power mode from the core, same clock
  input wire pcg_pkg::pcg_mode_e i_mode,
  // peripheral access request, same clock
  input wire pcg_pkg::pcg_acc_s i_acc,
  // outputs
  output logic o_bus_fault,
  output logic [31:0] o_clk_en,
  output logic o_irq
);
  import pcg_pkg::*;

  // gating registers, one per power mode
  logic [31:0] run_clock_gate_group1;
  logic [31:0] sleep_clock_gate_group1;
  logic [31:0] deep_sleep_clock_gate_group1;
  // clock config register holding the select bit
  logic [31:0] run_mode_clock_config;
  logic sleep_gating_select;
  // interrupt status and enable
  logic [`PCG_EV_BITS-1:0] int_stat;
  logic [`PCG_EV_BITS-1:0] int_en;
  // write channel capture
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // selected gate word and fault pulse
  logic [31:0] next_clk_en;
  logic fault;
  logic do_write;
  logic wr_hit;
  logic rd_take;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [`PCG_EV_BITS-1:0] ev;
  logic [`PCG_EV_BITS-1:0] clr;
  logic cfg_chg;

  assign sleep_gating_select = run_mode_clock_config[`PCG_CFG_SEL_BIT];

  // byte-lane merge, keeping only writable bits
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s,
                                        input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    return r & m;
  endfunction

  // mode-dependent register selection
  pcg_gate_sel u_sel (
    .i_run(run_clock_gate_group1),
    .i_sleep(sleep_clock_gate_group1),
    .i_deep(deep_sleep_clock_gate_group1),
    .i_sel(sleep_gating_select),
    .i_mode(i_mode),
    .o_gate(next_clk_en)
  );

  // fault check against the live enables
  pcg_fault_chk u_chk (
    .i_gate(o_clk_en),
    .i_acc(i_acc),
    .o_fault(fault)
  );

  // clock enables registered out
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_clk_en <= `PCG_GATE_RST;
    else
      o_clk_en <= next_clk_en;
  end

  // fault pulse registered out
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_bus_fault <= 1'b0;
    else
      o_bus_fault <= fault;
  end

  // write address capture
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (i_awvalid && o_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= i_awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  // write data capture
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (i_wvalid && o_wready)
    begin
      w_held <= 1'b1;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  // ready while nothing held and no response pending
  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready = !w_held && !o_bvalid;
  assign do_write = aw_held && w_held && !o_bvalid;

  // write address decode
  always_comb
  begin
    wr_hit = 1'b1;
    if (aw_addr[11:0] == `PCG_OFF_RUN)
      wr_hit = 1'b1;
    else if (aw_addr[11:0] == `PCG_OFF_SLEEP)
      wr_hit = 1'b1;
    else if (aw_addr[11:0] == `PCG_OFF_DEEP)
      wr_hit = 1'b1;
    else if (aw_addr[11:0] == `PCG_OFF_CFG)
      wr_hit = 1'b1;
    else if (aw_addr[11:0] == `PCG_OFF_IEN)
      wr_hit = 1'b1;
    else if (aw_addr[11:0] == `PCG_OFF_ICLR)
      wr_hit = 1'b1;
    else
      wr_hit = 1'b0;
  end

  // gating register writes
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      run_clock_gate_group1 <= `PCG_GATE_RST;
      sleep_clock_gate_group1 <= `PCG_GATE_RST;
      deep_sleep_clock_gate_group1 <= `PCG_GATE_RST;
    end
    else if (do_write)
    begin
      // reserved bits masked off so they read zero
      if (aw_addr[11:0] == `PCG_OFF_RUN)
        run_clock_gate_group1 <= merge(run_clock_gate_group1, w_data,
                                       w_strb, `PCG_GATE_MASK);
      else if (aw_addr[11:0] == `PCG_OFF_SLEEP)
        sleep_clock_gate_group1 <= merge(sleep_clock_gate_group1, w_data,
                                         w_strb, `PCG_GATE_MASK);
      else if (aw_addr[11:0] == `PCG_OFF_DEEP)
        deep_sleep_clock_gate_group1 <= merge(deep_sleep_clock_gate_group1,
                                              w_data, w_strb,
                                              `PCG_GATE_MASK);
    end
  end

  // clock config and interrupt enable writes
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      run_mode_clock_config <= '0;
      int_en <= '0;
    end
    else if (do_write)
    begin
      if (aw_addr[11:0] == `PCG_OFF_CFG)
        run_mode_clock_config <= merge(run_mode_clock_config, w_data,
                                       w_strb, `PCG_CFG_MASK);
      else if (aw_addr[11:0] == `PCG_OFF_IEN && w_strb[0])
        int_en <= w_data[`PCG_EV_BITS-1:0];
    end
  end

  // write response
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bvalid <= 1'b0;
      o_bresp <= `PCG_RESP_OKAY;
    end
    else if (do_write)
    begin
      o_bvalid <= 1'b1;
      o_bresp <= wr_hit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
    end
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  // events: bit 0 fault, bit 1 enable word changed
  assign cfg_chg = (next_clk_en != o_clk_en);
  assign ev = {cfg_chg, fault};
  assign clr = (do_write && aw_addr[11:0] == `PCG_OFF_ICLR && w_strb[0])
               ? w_data[`PCG_EV_BITS-1:0] : '0;

  // sticky status, set wins over clear
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      int_stat <= '0;
    else
      int_stat <= (int_stat & ~clr) | ev;
  end

  assign o_irq = |(int_stat & int_en);

  // read decode
  always_comb
  begin
    rd_hit = 1'b1;
    rd_word = '0;
    if (i_araddr[11:0] == `PCG_OFF_RUN)
      rd_word = run_clock_gate_group1;
    else if (i_araddr[11:0] == `PCG_OFF_SLEEP)
      rd_word = sleep_clock_gate_group1;
    else if (i_araddr[11:0] == `PCG_OFF_DEEP)
      rd_word = deep_sleep_clock_gate_group1;
    else if (i_araddr[11:0] == `PCG_OFF_CFG)
      rd_word = run_mode_clock_config;
    else if (i_araddr[11:0] == `PCG_OFF_ISTAT)
      rd_word = {30'h0, int_stat};
    else if (i_araddr[11:0] == `PCG_OFF_IEN)
      rd_word = {30'h0, int_en};
    else if (i_araddr[11:0] == `PCG_OFF_ICLR)
      rd_word = '0;
    else
      rd_hit = 1'b0;
  end

  assign o_arready = !o_rvalid;
  assign rd_take = i_arvalid && o_arready;

  // read response
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= `PCG_RESP_OKAY;
    end
    else if (rd_take)
    begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_word;
      o_rresp <= rd_hit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
    end
    else if (i_rready)
      o_rvalid <= 1'b0;
  end

  // checks
  a_reserved_zero: assert property
    (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_clk_en & ~`PCG_GATE_MASK) == 32'h0)
    else $error("reserved enable bit set");
  a_run_follow: assert property
    (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_mode == PCG_RUN) |=> o_clk_en == $past(run_clock_gate_group1))
    else $error("run register not applied");
  a_sleep_follow: assert property
    (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_mode == PCG_SLEEP && sleep_gating_select)
    |=> o_clk_en == $past(sleep_clock_gate_group1))
    else $error("sleep register not applied");
  a_deep_follow: assert property
    (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_mode == PCG_DEEP && !sleep_gating_select)
    |=> o_clk_en == $past(run_clock_gate_group1))
    else $error("deep sleep without select ignored run");
  a_fault_gate: assert property
    (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_acc.valid && i_acc.unit == 4'h7 && !o_clk_en[`PCG_BIT_ASYNC_SERIAL_ZERO_GATE])
    |=> o_bus_fault)
    else $error("missing fault on gated unit");
  a_no_fault: assert property
    (@(posedge i_mclk) disable iff (!i_rst_n)
    !i_acc.valid |=> !o_bus_fault)
    else $error("spurious fault");
  a_timer_map: assert property
    (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_acc.valid && i_acc.unit == 4'h2 && o_clk_en[`PCG_BIT_TMR0 + 2])
    |=> !o_bus_fault)
    else $error("timer two map wrong");
  a_bresp_hold: assert property
    (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_irq_level: assert property
    (@(posedge i_mclk) disable iff (!i_rst_n)
    fault && int_en[`PCG_EV_FAULT] && !do_write |=> o_irq)
    else $error("irq missing");
  c_sleep_sel: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_mode == PCG_SLEEP && sleep_gating_select);
  c_fault: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_bus_fault);
  c_write: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    do_write && wr_hit);
endmodule
`default_nettype wire

// ===== include/pcg_consts.svh
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH
// register byte offsets from the system control base
`define PCG_OFF_RUN 12'h104
`define PCG_OFF_SLEEP 12'h114
`define PCG_OFF_DEEP 12'h124
`define PCG_OFF_CFG 12'h060
`define PCG_OFF_ISTAT 12'h200
`define PCG_OFF_IEN 12'h204
`define PCG_OFF_ICLR 12'h208
// writable gate bits: comparator 24, timers 19:16, two-wire 14 and 12,
// sync serial 4, async serial 0
`define PCG_GATE_MASK 32'h010F5011
`define PCG_GATE_RST 32'h00000000
// sleep gating select position in the clock config register
`define PCG_CFG_SEL_BIT 27
`define PCG_CFG_MASK 32'h08000000
// interrupt event positions
`define PCG_EV_FAULT 0
`define PCG_EV_BITS 2
`define PCG_EV_MASK 2'h3
// unit slot positions inside the gate word
`define PCG_BIT_ASYNC_SERIAL_ZERO_GATE 0
`define PCG_BIT_SYNC_SERIAL_ZERO_GATE 4
`define PCG_BIT_TW0 12
`define PCG_BIT_TW1 14
`define PCG_BIT_TMR0 16
`define PCG_BIT_CMP0 24
// bus responses
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2
`endif

// ===== include/pcg_pkg.sv
package pcg_pkg;
  // power mode of the core
  typedef enum logic [1:0] {
    PCG_RUN = 2'b00,
    PCG_SLEEP = 2'b01,
    PCG_DEEP = 2'b10
  } pcg_mode_e;
  // unit access request from the peripheral bus
  typedef struct packed {
    logic valid;
    logic [3:0] unit;
  } pcg_acc_s;
endpackage

// ===== rtl/pcg_gate_sel.sv
`include "pcg_consts.svh"
`default_nettype none
module pcg_gate_sel
  import pcg_pkg::*;
(
  input wire logic [31:0] i_run,
  input wire logic [31:0] i_sleep,
  input wire logic [31:0] i_deep,
  input wire logic i_sel,
  input wire pcg_pkg::pcg_mode_e i_mode,
  output logic [31:0] o_gate
);
  // pick the register that applies to the present power mode
  always_comb
  begin
    o_gate = i_run;
    if (i_sel)
    begin
      case (i_mode)
        PCG_SLEEP: o_gate = i_sleep;
        PCG_DEEP: o_gate = i_deep;
        default: o_gate = i_run;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pcg_fault_chk.sv
`include "pcg_consts.svh"
`default_nettype none
module pcg_fault_chk
  import pcg_pkg::*;
(
  input wire logic [31:0] i_gate,
  input wire pcg_pkg::pcg_acc_s i_acc,
  output logic o_fault
);
  // map unit number to gate bit; 0..3 timers, 4,5 two-wire,
  // 6 sync serial, 7 async serial, 8 comparator
  function automatic logic unit_on(input logic [31:0] g,
                                   input logic [3:0] u);
    logic r;
    r = 1'b0;
    case (u)
      4'h0, 4'h1, 4'h2, 4'h3: r = g[`PCG_BIT_TMR0 + u[1:0]];
      4'h4: r = g[`PCG_BIT_TW0];
      4'h5: r = g[`PCG_BIT_TW1];
      4'h6: r = g[`PCG_BIT_SYNC_SERIAL_ZERO_GATE];
      4'h7: r = g[`PCG_BIT_ASYNC_SERIAL_ZERO_GATE];
      4'h8: r = g[`PCG_BIT_CMP0];
      default: r = 1'b1;
    endcase
    return r;
  endfunction
  // access to an unclocked unit is a fault
  assign o_fault = i_acc.valid && !unit_on(i_gate, i_acc.unit);
endmodule
`default_nettype wire

// ===== sim/peripheral_clock_gate_group1_tb_top.sv
`include "pcg_consts.svh"
`default_nettype none
module peripheral_clock_gate_group1_tb_top
  import pcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // one table row: register, value written, value read back
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wd;
    logic [31:0] exp;
  } pcg_row_s;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bus_fault, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, clk_en;
  pcg_mode_e mode = PCG_RUN;
  pcg_acc_s acc_q = '0;
  int fails = 0;
  int checks = 0;
  logic [1:0] r;
  logic [31:0] d;
  // gate bit of each unit number 0..8
  int ub[9] = '{16, 17, 18, 19, 12, 14, 4, 0, 24};
  pcg_row_s rows[8] = '{
    '{12'h104, 32'hFFFFFFFF, 32'h010F5011},
    '{12'h114, 32'hFFFFFFFF, 32'h010F5011},
    '{12'h124, 32'hFFFFFFFF, 32'h010F5011},
    '{12'h104, 32'h000F0000, 32'h000F0000},
    '{12'h114, 32'h01000000, 32'h01000000},
    '{12'h124, 32'h00005000, 32'h00005000},
    '{12'h104, 32'h00000011, 32'h00000011},
    '{12'h104, 32'hFEF0AFEE, 32'h00000000}};

  // 50 MHz clock
  always #10 i_mclk = ~i_mclk;

  pcg_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_mode(mode), .i_acc(acc_q),
    .o_bus_fault(bus_fault), .o_clk_en(clk_en), .o_irq(irq));

  // compare a word-wide result
  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  // compare a single flag
  task automatic chk_flag(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask

  // bus write; ready is sampled settled, acted on at the next edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    logic ah, wh, bh;
    ah = 1'b0;
    wh = 1'b0;
    bh = 1'b0;
    @(posedge i_mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh)
    begin
      @(negedge i_mclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bready && bvalid;
      rs = bresp;
      @(posedge i_mclk);
      if (ah)
        awvalid <= 1'b0;
      if (wh)
        wvalid <= 1'b0;
      if (bh)
        bready <= 1'b0;
    end
  endtask

  // bus read, data taken with the handshake
  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    logic ah, rh;
    ah = 1'b0;
    rh = 1'b0;
    @(posedge i_mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh)
    begin
      @(negedge i_mclk);
      ah = arvalid && arready;
      rh = rready && rvalid;
      v = rdata;
      rs = rresp;
      @(posedge i_mclk);
      if (ah)
        arvalid <= 1'b0;
      if (rh)
        rready <= 1'b0;
    end
  endtask

  // one-cycle unit access, fault looked at after the sampling edge
  task automatic acc(input logic [3:0] u, input logic e);
    @(posedge i_mclk);
    acc_q <= '{valid: 1'b1, unit: u};
    @(posedge i_mclk);
    acc_q <= '0;
    #1 chk_flag("bus_fault", e, bus_fault);
  endtask

  // change power mode, let the enable word settle
  task automatic go(input pcg_mode_e m, input logic [31:0] e);
    @(posedge i_mclk);
    mode <= m;
    repeat (3) @(posedge i_mclk);
    #1 chk_word("clk_en", e, clk_en);
  endtask

  // verdict and end of run
  task automatic give_verdict;
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog, far beyond the expected run length
  initial
  begin
    #400000;
    fails++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    // table of write and read back
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wd, r);
      chk_word("bresp", 32'(`PCG_RESP_OKAY), 32'(r));
      rd(rows[i].addr, d, r);
      chk_word("readback", rows[i].exp, d);
    end
    // distinct contents per register, selection across modes
    wr(12'h104, 32'h00010001, r);
    wr(12'h114, 32'h01000000, r);
    wr(12'h124, 32'h00004000, r);
    go(PCG_RUN, 32'h00010001);
    go(PCG_SLEEP, 32'h00010001);
    go(PCG_DEEP, 32'h00010001);
    wr(12'h060, 32'h08000000, r);
    go(PCG_SLEEP, 32'h01000000);
    go(PCG_DEEP, 32'h00004000);
    go(PCG_RUN, 32'h00010001);
    // fault on every gated unit, none on enabled ones
    for (int u = 0; u < 9; u++)
      acc(4'(u), !((32'h00010001 >> ub[u]) & 32'h1));
    acc(4'h9, 1'b0);
    // interrupt raise, clear and mask
    wr(12'h208, 32'h00000003, r);
    wr(12'h204, 32'h00000001, r);
    acc(4'h1, 1'b1);
    repeat (2) @(posedge i_mclk);
    #1 chk_flag("irq", 1'b1, irq);
    rd(12'h200, d, r);
    chk_word("status", 32'h1, d & 32'h1);
    wr(12'h208, 32'h00000001, r);
    repeat (2) @(posedge i_mclk);
    #1 chk_flag("irq", 1'b0, irq);
    wr(12'h204, 32'h00000000, r);
    acc(4'h2, 1'b1);
    repeat (2) @(posedge i_mclk);
    #1 chk_flag("irq", 1'b0, irq);
    // unmapped place
    rd(12'h300, d, r);
    chk_word("rresp", 32'(`PCG_RESP_SLVERR), 32'(r));
    wr(12'h300, 32'h1, r);
    chk_word("bresp", 32'(`PCG_RESP_SLVERR), 32'(r));
    // write response must stand while bready is held low
    @(posedge i_mclk);
    awaddr <= `PCG_OFF_IEN;
    wdata <= '0;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(posedge i_mclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1 chk_flag("bvalid held", 1'b1, bvalid);
    @(posedge i_mclk);
    bready <= 1'b1;
    @(posedge i_mclk);
    bready <= 1'b0;
    #1 chk_flag("bvalid taken", 1'b0, bvalid);
    // second reset in mid-run clears every gate
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1 chk_word("clk_en", 32'h0, clk_en);
    for (int k = 0; k < 3; k++)
    begin
      rd(12'h104 + 12'(16 * k), d, r);
      chk_word("reset value", `PCG_GATE_RST, d);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
